/* adcvr_chan.sv */
// one voltage channel: control/status byte, result buffer and selector decode
`include "adcvr_params.svh"

module adcvr_chan (
    input wire logic pclk,
    input wire logic presetn,
    adcvr_chan_if.chan bus
);
    logic done_q;
    logic done_d;
    logic rsvd_q;
    logic ie_q;
    logic [4:0] sel_q;
    adcvr_pkg::adcvr_result_t result_q;
    wire conv_take;
    wire clear_req;

    // conversions only land while the converter is on
    assign conv_take = bus.conv_done & bus.converter_on;
    assign clear_req = bus.ctl_wr & bus.wdata[`ADCVR_CTL_DONE_BIT];

    always_comb begin
        done_d = done_q;
        if (conv_take) begin
            done_d = 1'b1;
        end else if (!bus.converter_on || clear_req) begin
            done_d = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_q <= 1'b0;
            rsvd_q <= 1'b0;
            ie_q <= 1'b0;
            sel_q <= `ADCVR_SEL_RESET;
        end else begin
            done_q <= done_d;
            if (bus.ctl_wr) begin
                rsvd_q <= bus.wdata[`ADCVR_CTL_RSVD_BIT];
                ie_q <= bus.wdata[`ADCVR_CTL_IE_BIT];
                sel_q <= bus.wdata[`ADCVR_SEL_MSB:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_q <= '0;
        end else if (conv_take) begin
            result_q <= bus.conv_data;
        end
    end

    assign bus.ctl_byte = {done_q, rsvd_q, ie_q, sel_q};
    assign bus.result = result_q;
    // enabled rising edge of the done flag
    assign bus.done_event = ie_q & conv_take & ~done_q;
    // codes above the last input, the all-ones code among them, disable the channel
    assign bus.input_enable = (sel_q <= `ADCVR_SEL_LAST_INPUT);
    assign bus.input_index = sel_q[3:0];
endmodule : adcvr_chan

/* adcvr_chan_if.sv */
// signals between the register bank and one voltage channel
interface adcvr_chan_if;
    logic converter_on;
    logic ctl_wr;
    adcvr_pkg::adcvr_byte_t wdata;
    logic conv_done;
    adcvr_pkg::adcvr_result_t conv_data;
    adcvr_pkg::adcvr_byte_t ctl_byte;
    adcvr_pkg::adcvr_result_t result;
    logic done_event;
    logic [3:0] input_index;
    logic input_enable;

    modport regs (
        output converter_on,
        output ctl_wr,
        output wdata,
        output conv_done,
        output conv_data,
        input ctl_byte,
        input result,
        input done_event,
        input input_index,
        input input_enable
    );

    modport chan (
        input converter_on,
        input ctl_wr,
        input wdata,
        input conv_done,
        input conv_data,
        output ctl_byte,
        output result,
        output done_event,
        output input_index,
        output input_enable
    );
endinterface : adcvr_chan_if

/* adcvr_params.svh */
// register indices, field positions and reset values of the voltage result bank
`ifndef ADCVR_PARAMS_SVH
`define ADCVR_PARAMS_SVH

`define ADCVR_IDX_CH1_CTL 6'h06
`define ADCVR_IDX_CH1_LO 6'h07
`define ADCVR_IDX_CH1_HI 6'h08
`define ADCVR_IDX_CH2_CTL 6'h09
`define ADCVR_IDX_CH2_LO 6'h0A
`define ADCVR_IDX_CH2_HI 6'h0B
`define ADCVR_IDX_CH3_CTL 6'h0C
`define ADCVR_IDX_CH3_LO 6'h0D
`define ADCVR_IDX_CH3_HI 6'h0E
`define ADCVR_IDX_CAL_LO 6'h14
`define ADCVR_IDX_CAL_HI 6'h15
`define ADCVR_IDX_CONFIG 6'h20
`define ADCVR_IDX_IRQ_STAT 6'h21
`define ADCVR_IDX_IRQ_MASK 6'h22

`define ADCVR_NUM_CH 3
`define ADCVR_RESULT_W 14

`define ADCVR_CTL_DONE_BIT 7
`define ADCVR_CTL_RSVD_BIT 6
`define ADCVR_CTL_IE_BIT 5
`define ADCVR_SEL_MSB 4
`define ADCVR_CFG_ON_BIT 0

`define ADCVR_SEL_RESET 5'h1F
`define ADCVR_SEL_LAST_INPUT 5'h0D
`define ADCVR_CFG_RESET 1'h0
`define ADCVR_MASK_RESET 3'h0

`endif

/* adcvr_pkg.sv */
// types shared by the voltage result bank
package adcvr_pkg;

    typedef logic [13:0] adcvr_result_t;

    typedef logic [7:0] adcvr_byte_t;

    typedef enum {
        ADCVR_R_NONE,
        ADCVR_R_CTL,
        ADCVR_R_LO,
        ADCVR_R_HI,
        ADCVR_R_CAL_LO,
        ADCVR_R_CAL_HI,
        ADCVR_R_CFG,
        ADCVR_R_STAT,
        ADCVR_R_MASK
    } adcvr_reg_e;

    typedef struct packed {
        logic [1:0] chan;
        adcvr_reg_e kind;
    } adcvr_sel_s;

endpackage : adcvr_pkg

/* adcvr_regs.sv */
// APB register bank for three voltage channels and the high-scale calibration buffer
`include "adcvr_params.svh"

module adcvr_regs (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    output logic converter_on,
    input wire logic ch1_conv_done,
    input wire logic [13:0] ch1_conv_data,
    output logic [3:0] ch1_input_index,
    output logic ch1_input_enable,
    input wire logic ch2_conv_done,
    input wire logic [13:0] ch2_conv_data,
    output logic [3:0] ch2_input_index,
    output logic ch2_input_enable,
    input wire logic ch3_conv_done,
    input wire logic [13:0] ch3_conv_data,
    output logic [3:0] ch3_input_index,
    output logic ch3_input_enable,
    input wire logic cal_done,
    input wire logic [13:0] cal_data
);

    // index decode shared by the read and the write path
    function automatic adcvr_pkg::adcvr_sel_s decode_index(input logic [5:0] idx);
        adcvr_pkg::adcvr_sel_s s;
        s.chan = 2'h0;
        s.kind = adcvr_pkg::ADCVR_R_NONE;
        unique case (idx)
            `ADCVR_IDX_CH1_CTL: begin
                s.kind = adcvr_pkg::ADCVR_R_CTL;
            end
            `ADCVR_IDX_CH1_LO: begin
                s.kind = adcvr_pkg::ADCVR_R_LO;
            end
            `ADCVR_IDX_CH1_HI: begin
                s.kind = adcvr_pkg::ADCVR_R_HI;
            end
            `ADCVR_IDX_CH2_CTL: begin
                s.chan = 2'h1;
                s.kind = adcvr_pkg::ADCVR_R_CTL;
            end
            `ADCVR_IDX_CH2_LO: begin
                s.chan = 2'h1;
                s.kind = adcvr_pkg::ADCVR_R_LO;
            end
            `ADCVR_IDX_CH2_HI: begin
                s.chan = 2'h1;
                s.kind = adcvr_pkg::ADCVR_R_HI;
            end
            `ADCVR_IDX_CH3_CTL: begin
                s.chan = 2'h2;
                s.kind = adcvr_pkg::ADCVR_R_CTL;
            end
            `ADCVR_IDX_CH3_LO: begin
                s.chan = 2'h2;
                s.kind = adcvr_pkg::ADCVR_R_LO;
            end
            `ADCVR_IDX_CH3_HI: begin
                s.chan = 2'h2;
                s.kind = adcvr_pkg::ADCVR_R_HI;
            end
            `ADCVR_IDX_CAL_LO: begin
                s.kind = adcvr_pkg::ADCVR_R_CAL_LO;
            end
            `ADCVR_IDX_CAL_HI: begin
                s.kind = adcvr_pkg::ADCVR_R_CAL_HI;
            end
            `ADCVR_IDX_CONFIG: begin
                s.kind = adcvr_pkg::ADCVR_R_CFG;
            end
            `ADCVR_IDX_IRQ_STAT: begin
                s.kind = adcvr_pkg::ADCVR_R_STAT;
            end
            `ADCVR_IDX_IRQ_MASK: begin
                s.kind = adcvr_pkg::ADCVR_R_MASK;
            end
            default: begin
                s.kind = adcvr_pkg::ADCVR_R_NONE;
            end
        endcase
        return s;
    endfunction : decode_index

    // bus phases
    wire setup_phase;
    wire access_phase;
    wire wr_access;
    wire word_aligned;
    adcvr_pkg::adcvr_sel_s sel;
    wire mapped;

    assign setup_phase = psel & ~penable;
    assign access_phase = psel & penable;
    assign wr_access = access_phase & pwrite;
    assign word_aligned = (paddr[1:0] == 2'h0);
    assign sel = decode_index(paddr[7:2]);
    assign mapped = word_aligned & (sel.kind != adcvr_pkg::ADCVR_R_NONE);

    // write strobes
    wire wr_ctl_any;
    wire wr_cfg;
    wire wr_stat;
    wire wr_mask;

    assign wr_ctl_any = wr_access & word_aligned & (sel.kind == adcvr_pkg::ADCVR_R_CTL);
    assign wr_cfg = wr_access & word_aligned & (sel.kind == adcvr_pkg::ADCVR_R_CFG);
    assign wr_stat = wr_access & word_aligned & (sel.kind == adcvr_pkg::ADCVR_R_STAT);
    assign wr_mask = wr_access & word_aligned & (sel.kind == adcvr_pkg::ADCVR_R_MASK);

    // per-channel plumbing packed into vectors for the generate loop
    logic [`ADCVR_NUM_CH-1:0] conv_done_vec;
    adcvr_pkg::adcvr_result_t conv_data_arr [`ADCVR_NUM_CH];
    adcvr_pkg::adcvr_byte_t ctl_arr [`ADCVR_NUM_CH];
    adcvr_pkg::adcvr_result_t result_arr [`ADCVR_NUM_CH];
    logic [3:0] index_arr [`ADCVR_NUM_CH];
    logic [`ADCVR_NUM_CH-1:0] enable_vec;
    logic [`ADCVR_NUM_CH-1:0] event_vec;

    assign conv_done_vec = {ch3_conv_done, ch2_conv_done, ch1_conv_done};
    assign conv_data_arr[0] = ch1_conv_data;
    assign conv_data_arr[1] = ch2_conv_data;
    assign conv_data_arr[2] = ch3_conv_data;

    logic cfg_on_q;

    genvar gi;
    generate
        for (gi = 0; gi < `ADCVR_NUM_CH; gi++) begin : g_chan
            adcvr_chan_if u_if ();

            assign u_if.converter_on = cfg_on_q;
            assign u_if.ctl_wr = wr_ctl_any & (sel.chan == 2'(gi));
            assign u_if.wdata = pwdata[7:0];
            assign u_if.conv_done = conv_done_vec[gi];
            assign u_if.conv_data = conv_data_arr[gi];
            assign ctl_arr[gi] = u_if.ctl_byte;
            assign result_arr[gi] = u_if.result;
            assign index_arr[gi] = u_if.input_index;
            assign enable_vec[gi] = u_if.input_enable;
            assign event_vec[gi] = u_if.done_event;

            adcvr_chan u_chan (
                .pclk(pclk),
                .presetn(presetn),
                .bus(u_if.chan)
            );
        end
    endgenerate

    // converter enable; switching it off clears every done flag inside the channels
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_on_q <= `ADCVR_CFG_RESET;
        end else if (wr_cfg) begin
            cfg_on_q <= pwdata[`ADCVR_CFG_ON_BIT];
        end
    end

    // calibration buffer, loaded only when the converter is on
    adcvr_pkg::adcvr_result_t cal_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cal_q <= '0;
        end else if (cal_done & cfg_on_q) begin
            cal_q <= cal_data;
        end
    end

    // sticky interrupt status, write one to clear, a new event wins over the clear
    logic [`ADCVR_NUM_CH-1:0] stat_q;
    logic [`ADCVR_NUM_CH-1:0] stat_d;
    logic [`ADCVR_NUM_CH-1:0] mask_q;
    wire [`ADCVR_NUM_CH-1:0] stat_clr;

    assign stat_clr = wr_stat ? pwdata[`ADCVR_NUM_CH-1:0] : '0;
    assign stat_d = (stat_q & ~stat_clr) | event_vec;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_q <= '0;
            mask_q <= `ADCVR_MASK_RESET;
        end else begin
            stat_q <= stat_d;
            if (wr_mask) begin
                mask_q <= pwdata[`ADCVR_NUM_CH-1:0];
            end
        end
    end

    assign irq = |(stat_q & mask_q);

    // read selection; nothing here changes state, so reads have no side effect
    adcvr_pkg::adcvr_byte_t rd_byte;
    adcvr_pkg::adcvr_result_t rd_result;

    assign rd_result = result_arr[sel.chan];

    always_comb begin
        rd_byte = 8'h00;
        unique case (sel.kind)
            adcvr_pkg::ADCVR_R_CTL: begin
                rd_byte = ctl_arr[sel.chan];
            end
            adcvr_pkg::ADCVR_R_LO: begin
                rd_byte = rd_result[7:0];
            end
            adcvr_pkg::ADCVR_R_HI: begin
                rd_byte = {2'h0, rd_result[13:8]};
            end
            adcvr_pkg::ADCVR_R_CAL_LO: begin
                rd_byte = cal_q[7:0];
            end
            adcvr_pkg::ADCVR_R_CAL_HI: begin
                rd_byte = {2'h0, cal_q[13:8]};
            end
            adcvr_pkg::ADCVR_R_CFG: begin
                rd_byte = {7'h00, cfg_on_q};
            end
            adcvr_pkg::ADCVR_R_STAT: begin
                rd_byte = {5'h00, stat_q};
            end
            adcvr_pkg::ADCVR_R_MASK: begin
                rd_byte = {5'h00, mask_q};
            end
            adcvr_pkg::ADCVR_R_NONE: begin
                rd_byte = 8'h00;
            end
        endcase
    end

    // read data and error are captured in the setup cycle and held for the access cycle
    logic [31:0] prdata_q;
    logic pslverr_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else if (setup_phase) begin
            prdata_q <= (pwrite | ~mapped) ? 32'h0000_0000 : {24'h00_0000, rd_byte};
            pslverr_q <= ~mapped;
        end
    end

    assign prdata = prdata_q;
    assign pready = 1'b1;
    assign pslverr = pslverr_q & access_phase;

    assign converter_on = cfg_on_q;
    assign ch1_input_index = index_arr[0];
    assign ch2_input_index = index_arr[1];
    assign ch3_input_index = index_arr[2];
    assign ch1_input_enable = enable_vec[0];
    assign ch2_input_enable = enable_vec[1];
    assign ch3_input_enable = enable_vec[2];

endmodule : adcvr_regs

/* adcvr_regs_checker.sv */
// concurrent checks on the ports of the voltage result register bank
module adcvr_regs_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic irq,
    input wire logic converter_on,
    input wire logic [3:0] ch2_input_index,
    input wire logic ch2_input_enable
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    wire rd_acc = psel && penable && !pwrite;
    wire wr_acc = psel && penable && pwrite;

    property p_sel_dec;
        ch2_input_enable |-> ch2_input_index <= 4'hD;
    endproperty
    a_sel_dec: assert property (p_sel_dec) else $error("enabled input index out of range");
    property p_sel_wr;
        wr_acc && paddr == 8'h24 |=> ch2_input_index == $past(pwdata[3:0])
            && ch2_input_enable == ($past(pwdata[4:0]) <= 5'h0D);
    endproperty
    a_sel_wr: assert property (p_sel_wr) else $error("selector write not reflected");
    property p_hi_rsvd;
        rd_acc && paddr inside {8'h20, 8'h2C, 8'h38, 8'h54} |-> prdata[7:6] == 2'h0;
    endproperty
    a_hi_rsvd: assert property (p_hi_rsvd) else $error("reserved high bits not zero");
    property p_upper;
        rd_acc |-> prdata[31:8] == 24'h0;
    endproperty
    a_upper: assert property (p_upper) else $error("read data above bit 7 not zero");
    property p_err;
        pslverr |-> psel && penable;
    endproperty
    a_err: assert property (p_err) else $error("error outside access phase");
    property p_unmap;
        rd_acc && paddr == 8'hFC |-> pslverr && prdata == 32'h0;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not refused");
    property p_cfg;
        wr_acc && paddr == 8'h80 |=> converter_on == $past(pwdata[0]);
    endproperty
    a_cfg: assert property (p_cfg) else $error("converter enable not written");
    property p_irq_mask;
        wr_acc && paddr == 8'h88 && pwdata[2:0] == 3'h0 |=> !irq [*2];
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("irq high with all masked");
    c_irq: cover property (irq);
    c_err: cover property (rd_acc && pslverr);
    c_hi: cover property (rd_acc && paddr == 8'h54);
endmodule : adcvr_regs_checker

bind adcvr_regs adcvr_regs_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pslverr, .irq, .converter_on, .ch2_input_index, .ch2_input_enable);

/* adcvr_regs_test.sv */
// self-checking bench for the voltage result register bank
`include "adcvr_params.svh"

module adcvr_regs_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, converter_on, er;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] done, ien;
    logic [15:0] idx;
    logic [13:0] dat [4];
    logic [5:0] ci [4] = '{6'h00, `ADCVR_IDX_CH1_CTL, `ADCVR_IDX_CH2_CTL, `ADCVR_IDX_CH3_CTL};
    logic [5:0] lo [4] = '{`ADCVR_IDX_CAL_LO, `ADCVR_IDX_CH1_LO, `ADCVR_IDX_CH2_LO, `ADCVR_IDX_CH3_LO};
    logic [5:0] hi [4] = '{`ADCVR_IDX_CAL_HI, `ADCVR_IDX_CH1_HI, `ADCVR_IDX_CH2_HI, `ADCVR_IDX_CH3_HI};
    int mismatches, checks;

    adcvr_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .converter_on(converter_on), .ch1_conv_done(done[1]), .ch1_conv_data(dat[1]),
        .ch1_input_index(idx[7:4]), .ch1_input_enable(ien[1]), .ch2_conv_done(done[2]),
        .ch2_conv_data(dat[2]), .ch2_input_index(idx[11:8]), .ch2_input_enable(ien[2]),
        .ch3_conv_done(done[3]), .ch3_conv_data(dat[3]), .ch3_input_index(idx[15:12]),
        .ch3_input_enable(ien[3]), .cal_done(done[0]), .cal_data(dat[0]));
    assign idx[3:0] = 4'h0;
    assign ien[0] = 1'b0;

    task print_verdict;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : print_verdict

    task chk(input string n, input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            mismatches++;
            print_verdict();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task rreg(input logic [5:0] i, input logic [31:0] e);
        apb(1'b0, {i, 2'h0}, 32'h0);
        chk($sformatf("reg %h", i), rd, e);
    endtask : rreg

    task wreg(input logic [5:0] i, input logic [31:0] d);
        apb(1'b1, {i, 2'h0}, d);
    endtask : wreg

    task chk_irq(input logic e);
        @(negedge pclk);
        chk("irq", irq, e);
    endtask : chk_irq

    task chk_on(input logic e);
        @(negedge pclk);
        chk("converter_on", converter_on, e);
    endtask : chk_on

    task pulse(input int c, input logic [13:0] d);
        @(posedge pclk);
        done[c] <= 1'b1;
        dat[c] <= d;
        @(posedge pclk);
        done[c] <= 1'b0;
    endtask : pulse

    task t_reset;
        for (int c = 1; c < 4; c++) rreg(ci[c], 32'h1F);
        chk("idx", idx[15:4], 12'hFFF);
        chk("ien", ien, 4'h0);
    endtask : t_reset

    task t_conv;
        logic [13:0] d;
        wreg(`ADCVR_IDX_CONFIG, 32'h1);
        chk_on(1'b1);
        for (int c = 0; c < 4; c++) begin
            d = 14'h3A50 + 14'(c * 257);
            pulse(c, d);
            rreg(lo[c], {24'h0, d[7:0]});
            rreg(hi[c], {26'h0, d[13:8]});
            rreg(lo[c], {24'h0, d[7:0]});
            wreg(hi[c], 32'hFF);
            rreg(hi[c], {26'h0, d[13:8]});
            if (c > 0) begin
                rreg(ci[c], 32'h9F);
                wreg(ci[c], 32'h9F);
                rreg(ci[c], 32'h1F);
            end
        end
    endtask : t_conv

    task t_sel;
        logic [4:0] codes [5] = '{5'h00, 5'h0D, 5'h0E, 5'h1E, 5'h1F};
        foreach (codes[k]) begin
            wreg(ci[3], {27'h3, codes[k]});
            rreg(ci[3], {27'h3, codes[k]});
            chk("idx3", idx[15:12], codes[k][3:0]);
            chk("ien3", ien[3], codes[k] <= 5'h0D);
        end
        wreg(ci[3], 32'h1F);
    endtask : t_sel

    task t_irq;
        wreg(ci[2], 32'h3F);
        wreg(`ADCVR_IDX_IRQ_MASK, 32'h2);
        pulse(2, 14'h1234);
        rreg(`ADCVR_IDX_IRQ_STAT, 32'h2);
        chk_irq(1'b1);
        wreg(`ADCVR_IDX_IRQ_MASK, 32'h0);
        chk_irq(1'b0);
        wreg(`ADCVR_IDX_IRQ_MASK, 32'h2);
        chk_irq(1'b1);
        wreg(`ADCVR_IDX_IRQ_STAT, 32'h2);
        chk_irq(1'b0);
        pulse(1, 14'h0777);
        rreg(`ADCVR_IDX_IRQ_STAT, 32'h0);
        wreg(`ADCVR_IDX_CONFIG, 32'h0);
        chk_on(1'b0);
        rreg(ci[2], 32'h3F);
        rreg(ci[1], 32'h1F);
        pulse(1, 14'h0123);
        rreg(lo[1], 32'h77);
        rreg(ci[1], 32'h1F);
    endtask : t_irq

    task t_err;
        apb(1'b0, 8'hFC, 32'h0);
        chk("unmapped err", er, 1'b1);
        chk("unmapped data", rd, 32'h0);
        apb(1'b1, 8'h19, 32'h0);
        chk("unaligned", er, 1'b1);
        rreg(ci[1], 32'h1F);
    endtask : t_err

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata, done} = '0;
        dat = '{default: 14'h0};
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_conv();
        t_sel();
        t_irq();
        t_err();
        print_verdict();
    end
endmodule : adcvr_regs_test
